// ===== hdl/slcd_cfg.svh
// Notes on behaviour
// - reset clears both control registers to zero
// - high register write restarts divider and scan
// - run in idle; halt in stop unless sub clock
// - fetch display bytes E0H-FFH without processor help
// - segment n uses byte E0H+n, bit k common k
// - bit one drives on wave, zero off wave
// - high bit 3 selects the 2R transistor resistor
// - high bit 1: zero internal, one external bias
// - external bias disconnects internal divider resistors
// - duty/bias field picks commons and bias levels
// - codes 0110 and 1000 use 160k string
// - clock field picks 128 to 1024 Hz frames
`ifndef SLCD_CFG_SVH
`define SLCD_CFG_SVH

// register indices; byte address is four times these
`define SLCD_IDX_LO 10'h0eb
`define SLCD_IDX_HI 10'h0ec
`define SLCD_LO_RST 8'h00
`define SLCD_HI_RST 8'h00
// writable bits of each register
`define SLCD_LO_MASK 8'h3f
`define SLCD_HI_MASK 8'h0b
// field positions
`define SLCD_HI_DISPLAY_ON 0
`define SLCD_HI_BIAS_TYPE_SELECT 1
`define SLCD_HI_BIAS_RESISTOR_SELECT 3
`define SLCD_LO_LCLK 0
`define SLCD_LO_DBS 2
// display data window base
`define SLCD_RAM_BASE 8'he0
// watch timer rate and slowest frame clock, in Hz
`define SLCD_WCK_HZ 32768
`define SLCD_FLCD_MIN_HZ 128
// bus answers
`define SLCD_RESP_OKAY 2'h0
`define SLCD_RESP_SLVERR 2'h2

`endif

// ===== hdl/slcd_pkg.sv
package slcd_pkg;
  // bias level index, 0 = ground up to the bias count
  typedef logic [2:0] slcd_level_type;
  // display data fetch states
  typedef enum logic [1:0] {
    fs_idle = 2'b01,
    fs_scan = 2'b10
  } slcd_fetch_type;
endpackage

// ===== hdl/slcd_level.sv
`timescale 1ns/100ps
// picks the bias level for one common or segment pin
module slcd_level (
  input wire logic pol,
  input wire logic is_com,
  input wire logic sel,
  input wire logic active,
  input wire logic [2:0] bias,
  output slcd_pkg::slcd_level_type level
);
  import slcd_pkg::*;

  // the pair of levels swaps with the frame polarity so
  // every pixel sees zero average voltage
  always_comb
  begin
    level = 3'h0;
    if (!active)
    begin
      // blank pins sit at ground, no dc across the glass
      level = 3'h0;
    end
    else if (is_com)
    begin
      if (sel)
        level = pol ? bias : 3'h0;
      else
        level = pol ? 3'h1 : bias - 3'h1;
    end
    else if (sel)
    begin
      // pixel on: far side of the selected common
      level = pol ? 3'h0 : bias;
    end
    else if (bias == 3'h2)
    begin
      // half bias has only a middle level for off pixels
      level = 3'h1;
    end
    else
    begin
      level = pol ? 3'h2 : bias - 3'h2;
    end
  end
endmodule

// ===== hdl/slcd_top.sv
`timescale 1ns/100ps
`include "slcd_cfg.svh"
// segment lcd controller with axi4-lite control registers
module slcd_top #(
  parameter int NUM_SEG = 32,
  parameter int NUM_COM = 8,
  parameter int AW = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [AW-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [AW-1:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic watch_timer_clock,
  input wire logic stop_mode,
  input wire logic sys_clk_sub,
  output logic dmem_rd,
  output logic [7:0] dmem_addr,
  input wire logic [7:0] dmem_rdata,
  output slcd_pkg::slcd_level_type com_level [NUM_COM],
  output slcd_pkg::slcd_level_type seg_level [NUM_SEG],
  output logic bias_int_en,
  output logic bias_2r_sel,
  output logic bias_160k_sel,
  output logic [2:0] bias_count
);
  import slcd_pkg::*;

  // frame divider: watch timer ticks per slowest frame step
  localparam int BASE_DIV = `SLCD_WCK_HZ / `SLCD_FLCD_MIN_HZ;
  localparam logic [8:0] BASE_DIV_W = 9'(BASE_DIV);

  // control registers
  logic [7:0] ctl_lo_q;
  logic [7:0] ctl_hi_q;
  // write channel holding state
  logic aw_full_q;
  logic w_full_q;
  logic [9:0] widx_q;
  logic [31:0] wdata_q;
  logic wstrb0_q;
  logic aw_take;
  logic w_take;
  logic do_wr;
  logic aw_full_d;
  logic w_full_d;
  logic bvalid_d;
  logic rvalid_d;
  logic ar_take;
  logic [9:0] ridx;
  logic lo_wr;
  logic hi_wr;
  // decoded fields
  logic display_on;
  logic bias_type_select;
  logic bias_resistor_select;
  logic [3:0] duty_bias_select;
  logic [1:0] frame_clock_select;
  logic [3:0] ncom;
  logic [2:0] nbias;
  logic r160;
  logic duty_ok;
  // timing state
  logic halt;
  logic display_on_ok;
  logic run;
  logic [7:0] div_q;
  logic [7:0] div_lim;
  logic frame_tick;
  logic [3:0] slot_q;
  logic pol_q;
  // fetch state
  slcd_fetch_type fs_q;
  logic [4:0] fidx_q;
  logic rd_pend_q;
  logic [4:0] cap_idx_q;
  logic [7:0] shadow_q [32];
  // next pin levels
  slcd_level_type com_lvl_d [NUM_COM];
  slcd_level_type seg_lvl_d [NUM_SEG];

  // ---------------- axi4-lite write path ----------------
  assign aw_take = awvalid & awready;
  assign w_take = wvalid & wready;
  // both halves held and no answer pending: commit
  assign do_wr = aw_full_q & w_full_q & ~bvalid;
  assign aw_full_d = (aw_full_q | aw_take) & ~do_wr;
  assign w_full_d = (w_full_q | w_take) & ~do_wr;
  assign bvalid_d = do_wr | (bvalid & ~bready);
  // only the low byte lane carries register data
  assign lo_wr = do_wr & wstrb0_q & (widx_q == `SLCD_IDX_LO);
  assign hi_wr = do_wr & wstrb0_q & (widx_q == `SLCD_IDX_HI);

  // address and data are taken in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `SLCD_RESP_OKAY;
      widx_q <= 10'h000;
      wdata_q <= 32'h0000_0000;
      wstrb0_q <= 1'b0;
    end
    else
    begin
      aw_full_q <= aw_full_d;
      w_full_q <= w_full_d;
      // ready drops while a half is held or answer waits
      awready <= ~aw_full_d & ~bvalid_d;
      wready <= ~w_full_d & ~bvalid_d;
      bvalid <= bvalid_d;
      if (aw_take)
        widx_q <= awaddr[AW-1:2];
      if (w_take)
      begin
        wdata_q <= wdata;
        wstrb0_q <= wstrb[0];
      end
      if (do_wr)
      begin
        // unmapped words answer slverr
        if (widx_q == `SLCD_IDX_LO || widx_q == `SLCD_IDX_HI)
          bresp <= `SLCD_RESP_OKAY;
        else
          bresp <= `SLCD_RESP_SLVERR;
      end
    end
  end

  // ---------------- axi4-lite read path ----------------
  assign ar_take = arvalid & arready;
  assign rvalid_d = ar_take | (rvalid & ~rready);
  assign ridx = araddr[AW-1:2];

  // one read in flight; data is latched as the address is taken
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `SLCD_RESP_OKAY;
    end
    else
    begin
      arready <= ~rvalid_d;
      rvalid <= rvalid_d;
      if (ar_take)
      begin
        if (ridx == `SLCD_IDX_LO)
        begin
          rdata <= {24'h00_0000, ctl_lo_q};
          rresp <= `SLCD_RESP_OKAY;
        end
        else if (ridx == `SLCD_IDX_HI)
        begin
          rdata <= {24'h00_0000, ctl_hi_q};
          rresp <= `SLCD_RESP_OKAY;
        end
        else
        begin
          rdata <= 32'h0000_0000;
          rresp <= `SLCD_RESP_SLVERR;
        end
      end
    end
  end

  // ---------------- control registers ----------------
  // masked so unused bits stay zero whatever is written
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctl_lo_q <= `SLCD_LO_RST;
      ctl_hi_q <= `SLCD_HI_RST;
    end
    else
    begin
      if (lo_wr)
        ctl_lo_q <= wdata_q[7:0] & `SLCD_LO_MASK;
      if (hi_wr)
        ctl_hi_q <= wdata_q[7:0] & `SLCD_HI_MASK;
    end
  end

  assign display_on = ctl_hi_q[`SLCD_HI_DISPLAY_ON];
  assign bias_type_select = ctl_hi_q[`SLCD_HI_BIAS_TYPE_SELECT];
  assign bias_resistor_select = ctl_hi_q[`SLCD_HI_BIAS_RESISTOR_SELECT];
  assign duty_bias_select = ctl_lo_q[`SLCD_LO_DBS+:4];
  assign frame_clock_select = ctl_lo_q[`SLCD_LO_LCLK+:2];

  // duty and bias decode; unlisted codes blank the panel
  always_comb
  begin
    ncom = 4'h0;
    nbias = 3'h0;
    r160 = 1'b0;
    duty_ok = 1'b1;
    case (duty_bias_select)
      4'h0:
      begin
        ncom = 4'h8;
        nbias = 3'h4;
      end
      4'h1:
      begin
        ncom = 4'h6;
        nbias = 3'h4;
      end
      4'h2:
      begin
        ncom = 4'h5;
        nbias = 3'h3;
      end
      4'h3:
      begin
        ncom = 4'h4;
        nbias = 3'h3;
      end
      4'h4:
      begin
        ncom = 4'h3;
        nbias = 3'h3;
      end
      4'h5:
      begin
        ncom = 4'h3;
        nbias = 3'h2;
      end
      4'h6:
      begin
        ncom = 4'h3;
        nbias = 3'h2;
        r160 = 1'b1;
      end
      4'h7:
      begin
        ncom = 4'h2;
        nbias = 3'h2;
      end
      4'h8:
      begin
        ncom = 4'h2;
        nbias = 3'h2;
        r160 = 1'b1;
      end
      default:
      begin
        duty_ok = 1'b0;
      end
    endcase
  end

  // ---------------- frame timing ----------------
  // in stop mode only a sub clock system keeps the panel alive
  assign halt = stop_mode & ~sys_clk_sub;
  assign display_on_ok = display_on & duty_ok;
  assign run = display_on_ok & ~halt;
  // 256, 128, 64 or 32 watch ticks per step
  assign div_lim = 8'((BASE_DIV_W >> frame_clock_select) - 9'h001);
  assign frame_tick = run & watch_timer_clock & (div_q >= div_lim);

  // divider counts watch timer ticks into frame steps
  always_ff @(posedge aclk)
  begin
    if (!aresetn || hi_wr)
      div_q <= 8'h00;
    else if (run && watch_timer_clock)
      div_q <= frame_tick ? 8'h00 : div_q + 8'h01;
  end

  // common scan and frame polarity
  always_ff @(posedge aclk)
  begin
    if (!aresetn || hi_wr)
    begin
      slot_q <= 4'h0;
      pol_q <= 1'b0;
    end
    else if (frame_tick)
    begin
      // the >= also recovers when the duty shrinks mid scan
      if (slot_q >= ncom - 4'h1)
      begin
        slot_q <= 4'h0;
        pol_q <= ~pol_q;
      end
      else
      begin
        slot_q <= slot_q + 4'h1;
      end
    end
  end

  // ---------------- display data fetch ----------------
  // round robin over the window, one byte per cycle; costs
  // memory bandwidth but keeps the shadow within 32 cycles
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      fs_q <= fs_idle;
      fidx_q <= 5'h00;
      dmem_rd <= 1'b0;
      dmem_addr <= `SLCD_RAM_BASE;
    end
    else
    begin
      unique case (fs_q)
        fs_idle:
        begin
          dmem_rd <= 1'b0;
          fidx_q <= 5'h00;
          if (run)
            fs_q <= fs_scan;
        end
        fs_scan:
        begin
          if (!run)
          begin
            fs_q <= fs_idle;
            dmem_rd <= 1'b0;
          end
          else
          begin
            dmem_rd <= 1'b1;
            dmem_addr <= `SLCD_RAM_BASE | {3'h0, fidx_q};
            fidx_q <= fidx_q + 5'h01;
          end
        end
      endcase
    end
  end

  // read data is valid one cycle after memory sees the request
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rd_pend_q <= 1'b0;
      cap_idx_q <= 5'h00;
    end
    else
    begin
      rd_pend_q <= dmem_rd;
      cap_idx_q <= dmem_addr[4:0];
    end
  end

  // shadow copy of the display window, entry n for segment n
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int i = 0; i < 32; i++)
        shadow_q[i] <= 8'h00;
    end
    else if (rd_pend_q)
    begin
      shadow_q[cap_idx_q] <= dmem_rdata;
    end
  end

  // ---------------- pin level generation ----------------
  genvar g;
  generate
    for (g = 0; g < NUM_COM; g++)
    begin : g_com
      slcd_level u_com (
        .pol(pol_q),
        .is_com(1'b1),
        .sel(slot_q == 4'(g)),
        .active(display_on_ok && (4'(g) < ncom)),
        .bias(nbias),
        .level(com_lvl_d[g])
      );
    end
    for (g = 0; g < NUM_SEG; g++)
    begin : g_seg
      // bit k of the byte is the pixel on common k
      slcd_level u_seg (
        .pol(pol_q),
        .is_com(1'b0),
        .sel(shadow_q[g][slot_q[2:0]]),
        .active(display_on_ok),
        .bias(nbias),
        .level(seg_lvl_d[g])
      );
    end
  endgenerate

  // pins freeze while halted, as a stopped clock would leave them
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int i = 0; i < NUM_COM; i++)
        com_level[i] <= 3'h0;
      for (int i = 0; i < NUM_SEG; i++)
        seg_level[i] <= 3'h0;
    end
    else if (!halt)
    begin
      com_level <= com_lvl_d;
      seg_level <= seg_lvl_d;
    end
  end

  // bias network controls
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bias_int_en <= 1'b0;
      bias_2r_sel <= 1'b0;
      bias_160k_sel <= 1'b0;
      bias_count <= 3'h0;
    end
    else
    begin
      // internal divider only drawn from with internal bias
      bias_int_en <= display_on & ~bias_type_select;
      bias_2r_sel <= bias_resistor_select;
      bias_160k_sel <= r160 & ~bias_type_select;
      bias_count <= nbias;
    end
  end

  // ---------------- checks ----------------
  a_reset_clear: assert property (@(posedge aclk)
    !aresetn |=> ctl_lo_q == 8'h00 && ctl_hi_q == 8'h00)
    else $error("control registers not cleared by reset");

  a_hi_restart: assert property (@(posedge aclk) disable iff (!aresetn)
    hi_wr |=> div_q == 8'h00 && slot_q == 4'h0 && !pol_q)
    else $error("high register write did not restart timing");

  a_stop_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    halt && !hi_wr |=> $stable(div_q) && $stable(slot_q) && $stable(seg_level[0]))
    else $error("timing moved while halted in stop");

  a_fetch_window: assert property (@(posedge aclk) disable iff (!aresetn)
    dmem_rd |-> dmem_addr[7:5] == 3'h7)
    else $error("fetch outside display window");

  a_shadow_load: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_pend_q |=> shadow_q[$past(cap_idx_q)] == $past(dmem_rdata))
    else $error("display byte not stored at its segment");

  a_seg_on: assert property (@(posedge aclk) disable iff (!aresetn)
    run && pol_q && shadow_q[0][slot_q[2:0]] |=> seg_level[0] == 3'h0)
    else $error("on pixel not driven to on level");

  a_2r_follow: assert property (@(posedge aclk) disable iff (!aresetn)
    hi_wr && wdata_q[3] |=> ##1 bias_2r_sel)
    else $error("2R resistor not selected after write");

  a_ext_bias: assert property (@(posedge aclk) disable iff (!aresetn)
    ctl_hi_q[1] |=> !bias_int_en)
    else $error("internal divider kept with external bias");

  a_com_unused: assert property (@(posedge aclk) disable iff (!aresetn)
    duty_bias_select == 4'h7 && !halt |=> com_level[2] == 3'h0)
    else $error("unused common driven at half duty");

  a_res_160k: assert property (@(posedge aclk) disable iff (!aresetn)
    bias_160k_sel |-> $past(r160))
    else $error("160k string without matching code");

  a_frame_fast: assert property (@(posedge aclk) disable iff (!aresetn)
    run && watch_timer_clock && frame_clock_select == 2'h3 && div_q == 8'h1f && !hi_wr
    |=> div_q == 8'h00)
    else $error("1024 Hz divider did not wrap at 32 ticks");

  a_pol_flip: assert property (@(posedge aclk) disable iff (!aresetn)
    frame_tick && slot_q == ncom - 4'h1 && !hi_wr |=> pol_q != $past(pol_q))
    else $error("polarity did not flip at frame end");

  a_rsvd_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    ctl_lo_q[7:6] == 2'h0 && ctl_hi_q[7:4] == 4'h0 && !ctl_hi_q[2])
    else $error("reserved control bit set");
endmodule

// ===== verif/slcd_dmem_model.sv
`timescale 1ns/100ps
// data memory behind the display fetch port, one cycle read latency
module slcd_dmem_model (
  input wire logic aclk,
  input wire logic dmem_rd,
  input wire logic [7:0] dmem_addr,
  input wire logic [7:0] ram [32],
  output logic [7:0] dmem_rdata
);
  // answer the request sampled at this edge; idle cycles show the inverse
  // so a design that latches outside its request cannot pass by luck
  always_ff @(posedge aclk)
  begin
    if (dmem_rd)
      dmem_rdata <= ram[dmem_addr[4:0]];
    else
      dmem_rdata <= ~dmem_rdata;
  end
endmodule

// ===== verif/slcd_top_test.sv
`timescale 1ns/100ps
`include "slcd_cfg.svh"
// register and waveform tests for the segment lcd controller
module slcd_top_test;
  import slcd_pkg::*;
  localparam logic [11:0] LO = {`SLCD_IDX_LO, 2'b00}; // low control byte address
  localparam logic [11:0] HI = {`SLCD_IDX_HI, 2'b00}; // high control byte address
  logic aclk = 0, aresetn = 0;
  logic [11:0] awaddr = 0, araddr = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = 0;
  logic [3:0] wstrb = 0;
  logic awready, wready, bvalid, arready, rvalid, dmem_rd;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic watch_timer_clock = 0, stop_mode = 0, sys_clk_sub = 0;
  logic [7:0] dmem_addr, dmem_rdata;
  logic [7:0] ram [32]; // display bytes e0..ff
  slcd_level_type com_level [8];
  slcd_level_type seg_level [32];
  logic bias_int_en, bias_2r_sel, bias_160k_sel;
  logic [2:0] bias_count;
  int bad_count = 0, samples_checked = 0, cyc = 0;
  int ncom [9] = '{8, 6, 5, 4, 3, 3, 3, 2, 2}; // commons per duty code
  int nbias [9] = '{4, 4, 3, 3, 3, 2, 2, 2, 2}; // bias levels per duty code

  always #20 aclk = ~aclk; // 25 MHz

  slcd_top i_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .watch_timer_clock(watch_timer_clock), .stop_mode(stop_mode), .sys_clk_sub(sys_clk_sub),
    .dmem_rd(dmem_rd), .dmem_addr(dmem_addr), .dmem_rdata(dmem_rdata), .com_level(com_level),
    .seg_level(seg_level), .bias_int_en(bias_int_en), .bias_2r_sel(bias_2r_sel),
    .bias_160k_sel(bias_160k_sel), .bias_count(bias_count));

  slcd_dmem_model i_mem (.aclk(aclk), .dmem_rd(dmem_rd), .dmem_addr(dmem_addr), .ram(ram),
    .dmem_rdata(dmem_rdata));

  // verdict, reached from the main sequence or the timeout
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // four-state compare so an unknown never counts as a match
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e)
    begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask

  // axi4-lite write; address and data released each at its own handshake
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    bit ad, wd;
    ad = 0;
    wd = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do
    begin
      @(posedge aclk);
      if (!ad && awready === 1)
      begin
        awvalid <= 0;
        ad = 1;
      end
      if (!wd && wready === 1)
      begin
        wvalid <= 0;
        wd = 1;
      end
    end while (!(ad && wd));
    while (bvalid !== 1) @(posedge aclk);
    bready <= 0;
    chk(bresp, er);
  endtask

  // axi4-lite read with expected data and response
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do @(posedge aclk); while (arready !== 1);
    arvalid <= 0;
    while (rvalid !== 1) @(posedge aclk);
    rready <= 0;
    chk(rdata, e);
    chk(rresp, er);
  endtask

  // watch timer pulses, one aclk cycle high each; then let levels settle
  task automatic tk(input int n);
    repeat (n)
    begin
      @(posedge aclk);
      watch_timer_clock <= 1;
      @(posedge aclk);
      watch_timer_clock <= 0;
    end
    repeat (3) @(posedge aclk);
  endtask

  // expected pin levels for slot s, polarity p, bias count a, nc commons
  task automatic lv(input int s, input bit p, input int a, input int nc, input bit en);
    logic [31:0] e;
    for (int c = 0; c < 8; c++)
    begin
      e = (!en || c >= nc) ? 0 : (c == s) ? (p ? a : 0) : (p ? 1 : a - 1);
      chk(32'(com_level[c]), e);
    end
    for (int n = 0; n < 32; n++)
    begin
      e = !en ? 0 : ram[n][s] ? (p ? 0 : a) : (a == 2 ? 1 : (p ? 2 : a - 2));
      chk(32'(seg_level[n]), e);
    end
  endtask

  // fetch must stay inside the display window
  always @(posedge aclk)
  begin
    if (aresetn === 1 && dmem_rd === 1 && dmem_addr[7:5] !== 3'b111)
      chk(32'(dmem_addr), 32'h0000_00e0);
  end

  // hang guard, far above the few thousand cycles the run needs
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      bad_count++;
      results();
    end
  end

  initial
  begin
    for (int i = 0; i < 32; i++) ram[i] = 8'(i * 37) ^ 8'h5a;
    repeat (20) @(posedge aclk);
    aresetn <= 1;
    rd(LO, 32'h0000_0000, `SLCD_RESP_OKAY);
    rd(HI, 32'h0000_0000, `SLCD_RESP_OKAY);
    wr(LO, 32'hffff_ffff, 4'hf, `SLCD_RESP_OKAY);
    rd(LO, 32'h0000_003f, `SLCD_RESP_OKAY);
    wr(HI, 32'hffff_ffff, 4'hf, `SLCD_RESP_OKAY);
    rd(HI, 32'h0000_000b, `SLCD_RESP_OKAY);
    wr(LO, 32'h0000_0015, 4'h0, `SLCD_RESP_OKAY);
    rd(LO, 32'h0000_003f, `SLCD_RESP_OKAY);
    rd(12'h000, 32'h0000_0000, `SLCD_RESP_SLVERR);
    wr(12'h3b4, 32'h0000_0001, 4'hf, `SLCD_RESP_SLVERR);
    // each listed duty/bias code 0 to 8, at the restart slot
    for (int c = 0; c < 9; c++)
    begin
      wr(LO, 32'(c * 4 + 3), 4'hf, `SLCD_RESP_OKAY);
      wr(HI, 32'h0000_0001, 4'hf, `SLCD_RESP_OKAY);
      repeat (40) @(posedge aclk);
      chk(bias_count, nbias[c]);
      chk(bias_160k_sel, c == 6 || c == 8);
      chk(bias_int_en, 1);
      lv(0, 0, nbias[c], ncom[c], 1);
    end
    wr(LO, 32'h0000_0027, 4'hf, `SLCD_RESP_OKAY);
    repeat (40) @(posedge aclk);
    chk(bias_count, 0);
    lv(0, 0, 0, 0, 0);
    // frame clock codes: slot steps after 256 >> code watch ticks
    for (int k = 0; k < 4; k++)
    begin
      wr(LO, 32'(12 + k), 4'hf, `SLCD_RESP_OKAY);
      wr(HI, 32'h0000_0001, 4'hf, `SLCD_RESP_OKAY);
      repeat (40) @(posedge aclk);
      tk((256 >> k) - 1);
      lv(0, 0, 3, 4, 1);
      tk(1);
      lv(1, 0, 3, 4, 1);
    end
    tk(96);
    lv(0, 1, 3, 4, 1);
    wr(HI, 32'h0000_0001, 4'hf, `SLCD_RESP_OKAY);
    // pins follow the restarted scan one edge after the response
    repeat (2) @(posedge aclk);
    lv(0, 0, 3, 4, 1);
    // stop halts unless the sub clock runs the system
    stop_mode <= 1;
    tk(32);
    lv(0, 0, 3, 4, 1);
    sys_clk_sub <= 1;
    tk(32);
    lv(1, 0, 3, 4, 1);
    stop_mode <= 0;
    sys_clk_sub <= 0;
    // new display byte appears without any register access
    ram[5] <= ~ram[5];
    repeat (40) @(posedge aclk);
    lv(1, 0, 3, 4, 1);
    wr(HI, 32'h0000_000b, 4'hf, `SLCD_RESP_OKAY);
    // bias controls are registered from the control byte, one edge late
    repeat (2) @(posedge aclk);
    chk(bias_int_en, 0);
    chk(bias_2r_sel, 1);
    wr(HI, 32'h0000_0001, 4'hf, `SLCD_RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk(bias_int_en, 1);
    chk(bias_2r_sel, 0);
    wr(HI, 32'h0000_0000, 4'hf, `SLCD_RESP_OKAY);
    repeat (3) @(posedge aclk);
    lv(0, 0, 3, 4, 0);
    // second reset in mid-run
    aresetn <= 0;
    repeat (20) @(posedge aclk);
    aresetn <= 1;
    rd(LO, 32'h0000_0000, `SLCD_RESP_OKAY);
    rd(HI, 32'h0000_0000, `SLCD_RESP_OKAY);
    results();
  end
endmodule
